// File: verilog/sfb_bus_front.sv
// serial flash bus front end: select, lanes, pause, reset, quad mode
// assumes pins arrive raw; status bits come from the status register
`timescale 1ns/1ps

module sfb_bus_front
  import sfb_pkg::*;
#(
  parameter int unsigned SW_RST_CYCLES = `SFB_SWRST_CYCLES
)
(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       csN,
  input  wire logic       sck,
  input  wire logic [3:0] ioIn,
  output logic      [3:0] ioOut,
  output logic      [3:0] ioOeN,
  input  wire logic       dedResetN,
  input  wire logic       quadIoEnable,
  input  wire logic       holdRstSel,
  input  wire logic [1:0] statusProtectBits,
  input  wire logic       engineBusy,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic      [7:0] rxData,
  output logic            rxValid,
  output logic            rxOpcode,
  output logic            quadInstrMode,
  output logic            selected,
  output logic            paused,
  output logic            deviceBusy,
  output logic            resetActive,
  output logic            statusWriteLock
);

  localparam logic [`SFB_SWRST_CNT_W-1:0] RST_LOAD =
    SW_RST_CYCLES[`SFB_SWRST_CNT_W-1:0];

  sfb_pins_type  pinsRaw;
  sfb_pins_type  pinS;
  sfb_state_type state_r;
  sfb_state_type state_nxt;
  logic          sckRise;
  logic          sckFall;
  logic          csFall;
  logic          hwRst;
  logic          swBusy;
  logic          pauseEn;
  logic          swRstGo;

  assign pinsRaw = '{csN: csN, sck: sck, io: ioIn, rstN: dedResetN};

  sfb_pin_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .pinsIn   (pinsRaw),
    .pinsOut  (pinS)
  );

  // edges only count while selected, so the idle level is free
  assign sckRise = pinS.sck & ~state_r.sckPrev;
  assign sckFall = ~pinS.sck & state_r.sckPrev;
  assign csFall  = ~pinS.csN & state_r.csPrev;

  // dedicated pin always; shared pin only as reset, not quad
  assign hwRst = ~pinS.rstN
               | (~quadIoEnable & holdRstSel & ~pinS.io[3]);

  assign swBusy  = state_r.rstCnt != '0;
  assign pauseEn = ~quadIoEnable & ~holdRstSel & state_r.selected;

  // handshake: a byte is taken at a falling edge with an empty shifter
  assign txReady = state_r.selected & ~state_r.hold & ~pinS.csN
                 & sckFall & (state_r.outCnt == 4'h0);

  always_comb begin
    sfb_lane_type ln;
    logic [3:0]   step;
    logic [3:0]   cnt;
    logic [7:0]   nb;
    logic [7:0]   word;
    ln        = LANE_SINGLE;
    step      = 4'h1;
    cnt       = 4'h0;
    nb        = 8'h00;
    word      = 8'h00;
    swRstGo   = 1'b0;
    state_nxt = state_r;
    state_nxt.rx.valid = 1'b0;
    state_nxt.csPrev   = pinS.csN;
    state_nxt.sckPrev  = pinS.sck;

    if (hwRst) begin
      // highest priority: drop everything, including quad mode
      state_nxt        = '0;
      state_nxt.csPrev = pinS.csN;
      state_nxt.sckPrev = pinS.sck;
      state_nxt.ioOeN  = `SFB_OE_NONE;
    end else begin
      if (swBusy) begin
        state_nxt.rstCnt = state_r.rstCnt - 1'b1;
      end

      // pause changes only while the clock is low
      if (!pauseEn) begin
        state_nxt.hold = 1'b0;
      end else if ((pinS.io[3] == state_r.hold)
                   && (sckFall || !pinS.sck)) begin
        state_nxt.hold = ~pinS.io[3];
      end

      if (pinS.csN) begin
        // deselect abandons any half-shifted instruction
        state_nxt.selected = 1'b0;
        state_nxt.hold     = 1'b0;
        state_nxt.opDone   = 1'b0;
        state_nxt.bitCnt   = 4'h0;
        state_nxt.outCnt   = 4'h0;
        state_nxt.ioOeN    = `SFB_OE_NONE;
      end else if (csFall) begin
        state_nxt.armed    = 1'b1;
        state_nxt.selected = ~swBusy;
        state_nxt.inLanes  = state_r.quad_instruction_mode ? LANE_QUAD : LANE_SINGLE;
        state_nxt.outLanes = state_r.quad_instruction_mode ? LANE_QUAD : LANE_SINGLE;
      end else if (state_r.selected && state_r.armed
                   && !state_r.hold && !swBusy) begin
        if (sckRise) begin
          // opcode lanes follow the mode, later lanes the opcode
          if (state_r.opDone) begin
            ln = state_r.inLanes;
          end else if (state_r.quad_instruction_mode) begin
            ln = LANE_QUAD;
          end else begin
            ln = LANE_SINGLE;
          end
          case (ln)
            LANE_SINGLE: begin
              nb   = {state_r.shIn[6:0], pinS.io[0]};
              step = 4'h1;
            end
            LANE_DUAL: begin
              nb   = {state_r.shIn[5:0], pinS.io[1:0]};
              step = 4'h2;
            end
            LANE_QUAD: begin
              nb   = {state_r.shIn[3:0], pinS.io};
              step = 4'h4;
            end
            default: begin
              nb   = state_r.shIn;
              step = 4'h1;
            end
          endcase
          state_nxt.shIn   = nb;
          state_nxt.bitCnt = state_r.bitCnt + step;
          if (state_r.bitCnt + step == `SFB_BYTE_BITS) begin
            state_nxt.bitCnt    = 4'h0;
            state_nxt.rx.data   = nb;
            state_nxt.rx.valid  = 1'b1;
            state_nxt.rx.opcode = ~state_r.opDone;
            if (!state_r.opDone) begin
              state_nxt.opDone    = 1'b1;
              state_nxt.rstEnable = 1'b0;
              case (nb)
                `SFB_OP_DUAL_OUT: begin
                  if (!state_r.quad_instruction_mode) begin
                    state_nxt.outLanes = LANE_DUAL;
                  end
                end
                `SFB_OP_DUAL_IO: begin
                  if (!state_r.quad_instruction_mode) begin
                    state_nxt.inLanes  = LANE_DUAL;
                    state_nxt.outLanes = LANE_DUAL;
                  end
                end
                `SFB_OP_QUAD_OUT: begin
                  if (quadIoEnable) begin
                    state_nxt.outLanes = LANE_QUAD;
                  end
                end
                `SFB_OP_QUAD_IO: begin
                  if (quadIoEnable) begin
                    state_nxt.inLanes  = LANE_QUAD;
                    state_nxt.outLanes = LANE_QUAD;
                  end
                end
                `SFB_OP_QUAD_ENTER: begin
                  if (quadIoEnable) begin
                    state_nxt.quad_instruction_mode = 1'b1;
                  end
                end
                `SFB_OP_QUAD_EXIT: begin
                  state_nxt.quad_instruction_mode = 1'b0;
                end
                `SFB_OP_RST_ENABLE: begin
                  state_nxt.rstEnable = 1'b1;
                end
                `SFB_OP_RST: begin
                  if (state_r.rstEnable) begin
                    swRstGo          = 1'b1;
                    state_nxt.rstCnt = RST_LOAD;
                    state_nxt.quad_instruction_mode    = 1'b0;
                    state_nxt.selected = 1'b0;
                  end
                end
                default: begin
                  state_nxt.opDone = 1'b1;
                end
              endcase
            end
          end
        end

        if (sckFall) begin
          // lanes drive on falling edges, msb first
          cnt  = state_r.outCnt;
          word = state_r.shOut;
          if (cnt == 4'h0 && txValid) begin
            cnt  = `SFB_BYTE_BITS;
            word = txData;
          end
          if (cnt == 4'h0) begin
            state_nxt.ioOeN = `SFB_OE_NONE;
          end else begin
            case (state_r.outLanes)
              LANE_SINGLE: begin
                state_nxt.ioOut[1] = word[7];
                state_nxt.ioOeN    = `SFB_OE_SINGLE;
                state_nxt.shOut    = {word[6:0], 1'b0};
                state_nxt.outCnt   = cnt - 4'h1;
              end
              LANE_DUAL: begin
                state_nxt.ioOut[1:0] = word[7:6];
                state_nxt.ioOeN      = `SFB_OE_DUAL;
                state_nxt.shOut      = {word[5:0], 2'b00};
                state_nxt.outCnt     = cnt - 4'h2;
              end
              LANE_QUAD: begin
                state_nxt.ioOut  = word[7:4];
                state_nxt.ioOeN  = `SFB_OE_QUAD;
                state_nxt.shOut  = {word[3:0], 4'h0};
                state_nxt.outCnt = cnt - 4'h4;
              end
              default: begin
                state_nxt.ioOeN = `SFB_OE_NONE;
              end
            endcase
          end
        end
      end
      // last word: a pause starting on a fall must win over that shift
      if (state_nxt.hold) begin
        state_nxt.ioOeN = `SFB_OE_NONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r       <= '0;
      state_r.ioOeN <= `SFB_OE_NONE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign ioOut         = state_r.ioOut;
  assign ioOeN         = state_r.ioOeN;
  assign rxData        = state_r.rx.data;
  assign rxValid       = state_r.rx.valid;
  assign rxOpcode      = state_r.rx.opcode;
  assign quadInstrMode = state_r.quad_instruction_mode;
  assign selected      = state_r.selected;
  assign paused        = state_r.hold;
  assign resetActive   = hwRst | swBusy;

  // engine keeps running after deselect; only its own flag ends it
  assign deviceBusy = engineBusy | swBusy;

  // pin protection is meaningless once the pin carries lane 2
  assign statusWriteLock = statusProtectBits[`SFB_SP_LOCK_BIT]
                         | (statusProtectBits[`SFB_SP_HW_BIT]
                            & ~quadIoEnable & ~pinS.io[2]);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence sRstIssued;
    ce && swRstGo;
  endsequence

  sequence sRstHeld;
    swBusy [*8];
  endsequence

  property pSwResetHolds;
    sRstIssued |=> sRstHeld;
  endproperty

  a_deselect_release: assert property (
    ce && pinS.csN |=> ioOeN == `SFB_OE_NONE)
    else $error("outputs driven while deselected");

  a_select_needs_fall: assert property (
    ce && !state_r.armed && !csFall && !state_r.selected
    |=> !selected)
    else $error("selected without a select falling edge");

  a_quad_entry_qe: assert property (
    ce && !quadIoEnable && !state_r.quad_instruction_mode |=> !quadInstrMode)
    else $error("quad mode entered without quad io enable");

  a_pause_release: assert property (
    paused |-> ioOeN == `SFB_OE_NONE ##1 ioOeN == `SFB_OE_NONE)
    else $error("output driven during pause");

  a_pause_off_qe: assert property (
    ce && quadIoEnable |=> !paused)
    else $error("pause active with quad io enable");

  a_hw_reset_clears: assert property (
    ce && !pinS.rstN |=> !quadInstrMode && !selected && !rxValid)
    else $error("hardware reset did not clear state");

  a_swreset_busy: assert property (pSwResetHolds)
    else $error("software reset busy too short");

  a_swreset_spi: assert property (
    sRstIssued |=> !quadInstrMode)
    else $error("software reset left quad mode on");

  a_rx_on_rise: assert property (
    $rose(rxValid) |-> $past(sckRise))
    else $error("byte completed without a rising edge");

  a_tx_on_fall: assert property (
    ce && !hwRst && !pinS.csN && !sckFall |=> $stable(ioOut))
    else $error("output lane changed away from a falling edge");

  a_quad_lane_qe: assert property (
    ce && !hwRst && sckFall && !quadIoEnable && !state_r.quad_instruction_mode
    && state_r.outLanes != LANE_QUAD |=> ioOeN[3])
    else $error("lane 3 driven without quad io enable");

endmodule

// File: verilog/sfb_defines.svh
// constants of the serial flash bus front end
// assumes a single 250 MHz core clock oversampling the bus pins
`ifndef SFB_DEFINES_SVH
`define SFB_DEFINES_SVH

// core clock rate
`define SFB_CLK_MHZ        250

// software reset recovery time, microseconds, and its cycle count
`define SFB_SWRST_US       30
`define SFB_SWRST_CYCLES   (`SFB_SWRST_US * `SFB_CLK_MHZ)
`define SFB_SWRST_CNT_W    13

// bits per byte and per opcode
`define SFB_BYTE_BITS      4'h8

// opcodes
`define SFB_OP_DUAL_OUT    8'h3b
`define SFB_OP_DUAL_IO     8'hbb
`define SFB_OP_QUAD_OUT    8'h6b
`define SFB_OP_QUAD_IO     8'heb
`define SFB_OP_QUAD_ENTER  8'h38
`define SFB_OP_QUAD_EXIT   8'hff
`define SFB_OP_RST_ENABLE  8'h66
`define SFB_OP_RST         8'h99

// output enables, low means driven
`define SFB_OE_NONE        4'hf
`define SFB_OE_SINGLE      4'hd
`define SFB_OE_DUAL        4'hc
`define SFB_OE_QUAD        4'h0

// status protect bit positions
`define SFB_SP_HW_BIT      0
`define SFB_SP_LOCK_BIT    1

`endif

// File: verilog/sfb_pkg.sv
// types shared by the serial flash bus front end
// assumes sfb_defines.svh is on the include path
`include "sfb_defines.svh"

package sfb_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE,
    LANE_DUAL,
    LANE_QUAD
  } sfb_lane_type;

  typedef struct packed {
    logic       csN;
    logic       sck;
    logic [3:0] io;
    logic       rstN;
  } sfb_pins_type;

  typedef struct packed {
    sfb_pins_type stage1;
    sfb_pins_type stage2;
  } sfb_sync_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       opcode;
  } sfb_rx_type;

  typedef struct packed {
    logic                         csPrev;
    logic                         sckPrev;
    logic                         armed;
    logic                         selected;
    logic                         quad_instruction_mode;
    logic                         rstEnable;
    logic                         hold;
    logic                         opDone;
    logic [`SFB_SWRST_CNT_W-1:0]  rstCnt;
    sfb_lane_type                 inLanes;
    sfb_lane_type                 outLanes;
    logic [3:0]                   bitCnt;
    logic [7:0]                   shIn;
    logic [3:0]                   outCnt;
    logic [7:0]                   shOut;
    logic [3:0]                   ioOut;
    logic [3:0]                   ioOeN;
    sfb_rx_type                   rx;
  } sfb_state_type;

endpackage

// File: verilog/sfb_pin_sync.sv
// two-stage synchroniser for the bus pins
// assumes pins are asynchronous to core_clk; idle pins read high
`timescale 1ns/1ps

module sfb_pin_sync
  import sfb_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire sfb_pins_type pinsIn,
  output sfb_pins_type      pinsOut
);

  sfb_sync_state_type state_r;
  sfb_sync_state_type state_nxt;

  // stage1 feeds stage2 only
  always_comb begin
    state_nxt        = state_r;
    state_nxt.stage1 = pinsIn;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= '1;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  assign pinsOut = state_r.stage2;

endmodule

// File: tb/sfb_host_model.sv
// host-side model of a flash bus controller: select, clock, lanes
// assumes the shared core clock; one clock phase lasts HALF core cycles
`timescale 1ns/1ps

module sfb_host_model
#(
  parameter int HALF = 6
)
(
  input  wire logic       core_clk,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOeN,
  output logic            csN,
  output logic            sck,
  output logic      [3:0] pinLevel
);
  logic       cpol   = 1'b0;
  logic       noise  = 1'b0;
  logic [3:0] hostIo = 4'hc;
  logic [3:0] hostOe = 4'hc;

  initial begin
    csN = 1'b1;
    sck = 1'b0;
  end

  // released io0/io1 float, so they toggle; io2/io3 have pull-ups
  always @(posedge core_clk) noise <= ~noise;
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      if (!ioOeN[j]) pinLevel[j] = ioOut[j];
      else if (hostOe[j]) pinLevel[j] = hostIo[j];
      else pinLevel[j] = (j > 1) ? 1'b1 : noise ^ (j == 1);
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // clock parked at its idle level across both select edges
  task automatic cs(input logic v);
    sck = cpol;
    tick(HALF);
    csN = v;
    tick(HALF);
  endtask

  // lanes change after the fall, device samples at the rise
  task automatic clk_out(input logic [3:0] v, input int w);
    sck = 1'b0;
    for (int j = 0; j < w; j++) hostIo[j] = v[j];
    hostOe[1:0] = (w > 1) ? 2'h3 : 2'h1;
    tick(HALF);
    sck = 1'b1;
    tick(HALF);
  endtask

  // msb first; eight serial clocks or two quad clocks per byte
  task automatic put(input logic [7:0] b, input int w);
    for (int k = 8 / w - 1; k >= 0; k--) clk_out(4'(b >> (k * w)), w);
    hostOe[1:0] = 2'h0;
    hostIo[3:2] = 2'h3;
  endtask

  // sample just before the rise, a full phase after the launching fall
  task automatic get(input int w, output logic [7:0] r);
    // single lane: host keeps io0 low, so the rises shift in zeros
    hostOe    = (w == 4) ? 4'h0 : (w == 2) ? 4'hc : 4'hd;
    hostIo[0] = 1'b0;
    r = 8'h00;
    for (int k = 8 / w - 1; k >= 0; k--) begin
      sck = 1'b0;
      tick(HALF);
      for (int j = 0; j < w; j++) r[k * w + j] = pinLevel[(w == 1) ? 1 : j];
      sck = 1'b1;
      tick(HALF);
    end
    hostOe = 4'hc;
  endtask
endmodule

// File: tb/sfb_bus_front_tb_top.sv
// testbench of the flash bus front end, driven through the host model
// assumes 250 MHz core clock; short software reset count for run time
`timescale 1ns/1ps
`include "sfb_defines.svh"

module sfb_bus_front_tb_top;
  logic       core_clk          = 1'b0;
  logic       srst              = 1'b1;
  logic       ce                = 1'b1;
  logic       dedResetN         = 1'b1;
  logic       quadIoEnable      = 1'b0;
  logic       holdRstSel        = 1'b0;
  logic       engineBusy        = 1'b0;
  logic       txValid           = 1'b0;
  logic       sawReady          = 1'b0;
  logic [1:0] statusProtectBits = 2'h0;
  logic [7:0] txData            = 8'h00;
  logic [7:0] txQ[$];
  logic [8:0] rxQ[$];
  int         errors            = 0;
  int         n_tests           = 0;
  wire        csN, sck, txReady, rxValid, rxOpcode, quadInstrMode;
  wire        selected, paused, deviceBusy, resetActive, statusWriteLock;
  wire  [3:0] pinLevel, ioOut, ioOeN;
  wire  [7:0] rxData;

  sfb_bus_front #(.SW_RST_CYCLES(40)) dut (
    .core_clk          (core_clk),
    .srst              (srst),
    .ce                (ce),
    .csN               (csN),
    .sck               (sck),
    .ioIn              (pinLevel),
    .ioOut             (ioOut),
    .ioOeN             (ioOeN),
    .dedResetN         (dedResetN),
    .quadIoEnable      (quadIoEnable),
    .holdRstSel        (holdRstSel),
    .statusProtectBits (statusProtectBits),
    .engineBusy        (engineBusy),
    .txData            (txData),
    .txValid           (txValid),
    .txReady           (txReady),
    .rxData            (rxData),
    .rxValid           (rxValid),
    .rxOpcode          (rxOpcode),
    .quadInstrMode     (quadInstrMode),
    .selected          (selected),
    .paused            (paused),
    .deviceBusy        (deviceBusy),
    .resetActive       (resetActive),
    .statusWriteLock   (statusWriteLock)
  );
  sfb_host_model host (
    .core_clk (core_clk),
    .ioOut    (ioOut),
    .ioOeN    (ioOeN),
    .csN      (csN),
    .sck      (sck),
    .pinLevel (pinLevel)
  );

  always #2 core_clk = ~core_clk;

  // pulses read mid-cycle, where they have settled
  always @(negedge core_clk) begin
    sawReady = txReady === 1'b1;
    if (rxValid === 1'b1) rxQ.push_back({rxOpcode, rxData});
  end

  // read bytes: txValid held until the byte is taken
  always @(posedge core_clk) begin
    #1;
    if (sawReady && txQ.size() > 0) void'(txQ.pop_front());
    txValid = txQ.size() > 0;
    txData = txValid ? txQ[0] : 8'h00;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic fl(input logic s, input logic e);
    chk({8'h0, s}, {8'h0, e});
  endtask

  task automatic rx(input logic [8:0] e);
    chk(rxQ.size() > 0 ? rxQ.pop_front() : 9'bx, e);
  endtask

  task automatic op1(input logic [7:0] op, input int w);
    host.cs(1'b0);
    host.put(op, w);
    rx({1'b1, op});
    host.cs(1'b1);
  endtask

  task automatic io_in(input logic [7:0] op, d, input int w);
    host.cs(1'b0);
    host.put(op, 1);
    rx({1'b1, op});
    host.put(d, w);
    rx({1'b0, d});
    host.cs(1'b1);
  endtask

  task automatic rd(input logic [7:0] op, d, input int w,
                    input logic [3:0] oe);
    logic [7:0] r;
    host.cs(1'b0);
    host.put(op, quadInstrMode === 1'b1 ? 4 : 1);
    rx({1'b1, op});
    txQ.push_back(d);
    host.get(w, r);
    chk({5'h0, ioOeN}, {5'h0, oe});
    chk({1'b0, r}, {1'b0, d});
    // the read's own rises also fill the input shifter
    if (w == 1) rx(9'h000);
    else if (quadInstrMode === 1'b1) rx({1'b0, d});
    host.cs(1'b1);
    chk({5'h0, ioOeN}, {5'h0, `SFB_OE_NONE});
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  initial begin
    host.tick(10);
    chk({2'h0, ioOeN, quadInstrMode, selected, paused}, 9'h078);
    srst = 1'b0;
    host.tick(4);
    host.cs(1'b0);
    fl(selected, 1'b1);
    host.cs(1'b1);
    op1(8'h5a, 1);
    io_in(8'h02, 8'hc3, 1);
    rd(8'h0b, 8'ha5, 1, `SFB_OE_SINGLE);
    rd(`SFB_OP_DUAL_OUT, 8'h96, 2, `SFB_OE_DUAL);
    io_in(`SFB_OP_DUAL_IO, 8'h81, 2);
    rd(`SFB_OP_QUAD_OUT, 8'h3c, 1, `SFB_OE_SINGLE);
    io_in(`SFB_OP_QUAD_IO, 8'h7e, 1);
    op1(`SFB_OP_QUAD_ENTER, 1);
    fl(quadInstrMode, 1'b0);
    quadIoEnable = 1'b1;
    rd(`SFB_OP_QUAD_OUT, 8'hc3, 4, `SFB_OE_QUAD);
    io_in(`SFB_OP_QUAD_IO, 8'h7e, 4);
    op1(`SFB_OP_QUAD_ENTER, 1);
    fl(quadInstrMode, 1'b1);
    op1(8'h9c, 4);
    rd(`SFB_OP_DUAL_OUT, 8'h5e, 4, `SFB_OE_QUAD);
    op1(`SFB_OP_QUAD_EXIT, 4);
    fl(quadInstrMode, 1'b0);
    op1(`SFB_OP_QUAD_ENTER, 1);
    op1(`SFB_OP_RST_ENABLE, 4);
    op1(`SFB_OP_RST, 4);
    chk({6'h0, deviceBusy, resetActive, quadInstrMode}, 9'h006);
    host.cs(1'b0);
    fl(selected, 1'b0);
    host.cs(1'b1);
    for (int i = 0; i < 60 && deviceBusy !== 1'b0; i++) host.tick(1);
    fl(deviceBusy, 1'b0);
    host.cpol = 1'b1;
    op1(8'ha7, 1);
    rd(8'h0b, 8'h69, 1, `SFB_OE_SINGLE);
    host.cpol = 1'b0;
    host.cs(1'b0);
    repeat (4) host.clk_out(4'h1, 1);
    host.cs(1'b1);
    op1(8'h42, 1);
    host.cs(1'b0);
    host.hostIo[3] = 1'b0;
    host.tick(6);
    fl(paused, 1'b0);
    host.hostIo[3] = 1'b1;
    host.cs(1'b1);
    // pause asked with the clock high waits for its fall
    quadIoEnable = 1'b0;
    host.cs(1'b0);
    repeat (4) host.clk_out(4'h1, 1);
    host.hostIo[3] = 1'b0;
    host.tick(6);
    fl(paused, 1'b0);
    host.sck = 1'b0;
    host.tick(6);
    chk({3'h0, paused, resetActive, ioOeN}, 9'h02f);
    repeat (3) host.clk_out(4'h0, 1);
    host.hostIo[3] = 1'b1;
    host.tick(6);
    fl(paused, 1'b1);
    host.sck = 1'b0;
    host.tick(6);
    fl(paused, 1'b0);
    repeat (4) host.clk_out(4'h0, 1);
    rx(9'h1f0);
    host.cs(1'b1);
    holdRstSel = 1'b1;
    host.hostIo[3] = 1'b0;
    host.tick(6);
    fl(resetActive, 1'b1);
    quadIoEnable = 1'b1;
    host.tick(6);
    fl(resetActive, 1'b0);
    // clock enable low freezes the pin synchroniser too
    ce = 1'b0;
    dedResetN = 1'b0;
    host.tick(6);
    fl(resetActive, 1'b0);
    ce = 1'b1;
    host.tick(6);
    fl(resetActive, 1'b1);
    dedResetN = 1'b1;
    host.hostIo[3] = 1'b1;
    holdRstSel = 1'b0;
    engineBusy = 1'b1;
    host.tick(6);
    fl(deviceBusy, 1'b1);
    engineBusy = 1'b0;
    for (int i = 0; i < 16; i++) begin
      {statusProtectBits, quadIoEnable, host.hostIo[2]} = 4'(i);
      host.tick(4);
      fl(statusWriteLock, i[3] | (i[2] & !i[1] & !i[0]));
    end
    give_verdict();
  end
endmodule
